// ===== include/pulse_event_accumulator_regs.svh
// constants for the pulse event accumulator: widths, limits, reset values and timing
`ifndef PULSE_EVENT_ACCUMULATOR_REGS_SVH
`define PULSE_EVENT_ACCUMULATOR_REGS_SVH

// ****************************************************************
// widths and limits
// ****************************************************************
`define PEA_TALLY_WIDTH 24
`define PEA_TALLY_MAX 24'h98967f
`define PEA_TALLY_RESET 24'h000000
`define PEA_RATE_RESET 24'h000000
`define PEA_CMD_WIDTH 3

// ****************************************************************
// timing
// ****************************************************************
`define PEA_CLK_PERIOD_NS 4
`define PEA_DEBOUNCE_US 2000
`define PEA_DEBOUNCE_CYCLES ((`PEA_DEBOUNCE_US * 1000) / `PEA_CLK_PERIOD_NS)
`define PEA_RATE_GATE_MS 1000
`define PEA_RATE_GATE_CYCLES ((`PEA_RATE_GATE_MS * 1000000) / `PEA_CLK_PERIOD_NS)

`endif

// ===== include/pulse_event_accumulator_pkg.sv
// types shared by the pulse event accumulator modules
package pulse_event_accumulator_pkg;

    // ****************************************************************
    // host commands and answers
    // ****************************************************************
    typedef enum logic [2:0] {
        rate_sample_cmd,
        tally_query_cmd,
        zero_tally_cmd,
        fetch_and_zero_cmd,
        host_soft_restart_cmd
    } cmd_type;

    typedef enum logic [1:0] {
        rsp_ok,
        rsp_bad_command,
        rsp_rate_not_ready
    } rsp_status_type;

    typedef logic [23:0] tally_type;

endpackage

// ===== include/pulse_condition_if.sv
// qualified edge signals from the input conditioner to the accumulator core
`timescale 1ns/100ps
interface pulse_condition_if;
    logic rate_edge;
    logic count_edge;
    logic input_level;

    modport producer (
        output rate_edge,
        output count_edge,
        output input_level
    );
    modport consumer (
        input rate_edge,
        input count_edge,
        input input_level
    );
endinterface // pulse_condition_if

// ===== logic/pulse_input_conditioner.sv
// synchroniser, contact debounce and edge detection for the counter input
`timescale 1ns/100ps
module pulse_input_conditioner #(
    parameter int debounce_cycles = 500000
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // raw comparator output and filter choice
    input wire logic raw_input,
    input wire logic switch_filter_on,
    // qualified edges
    pulse_condition_if.producer cond
);

    logic sync_a;
    logic sync_b;
    logic sync_prev;
    logic stable_level;
    logic stable_prev;
    logic [31:0] settle_count;

    // two-flop synchroniser; sync_a feeds nothing but sync_b
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_prev <= 1'b0;
        end else begin
            sync_a <= raw_input;
            sync_b <= sync_a;
            sync_prev <= sync_b; // [R13]
        end
    end

    // level is accepted only after it has held for the full settle time
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            stable_level <= 1'b0;
            settle_count <= 32'h00000000;
        end else if (sync_b == stable_level) begin
            settle_count <= 32'h00000000;
        end else if (settle_count >= 32'(debounce_cycles - 1)) begin
            stable_level <= sync_b; // [R12]
            settle_count <= 32'h00000000;
        end else begin
            settle_count <= settle_count + 32'h00000001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            stable_prev <= 1'b0;
        end else begin
            stable_prev <= stable_level;
        end
    end

    // edges are muxed, not levels, so a filter change cannot fake a count
    assign cond.rate_edge = sync_b && !sync_prev; // [R01]
    assign cond.count_edge = switch_filter_on ? (stable_level && !stable_prev)
                                              : (sync_b && !sync_prev); // [R12] [R13]
    assign cond.input_level = sync_b;

endmodule // pulse_input_conditioner

// ===== logic/pulse_event_accumulator.sv
// event accumulator and rate meter for the pulse input, with host command port
`timescale 1ns/100ps
`include "pulse_event_accumulator_regs.svh"

// Notes on behaviour
// (R01) The conditioned comparator output feeds both the rate meter and the event counter; the rate meter never sees the debounce filter.
// (R02) A rate sample command answers with the latest measured input rate.
// (R03) A tally query command answers with the count since the last clear, leaving it as is.
// (R04) The event counter counts the digital input numbered zero.
// (R05) The count stops at 9,999,999 and holds there while further events arrive.
// (R06) A zero tally command sets the count to zero.
// (R07) A fetch and zero command reports the count and then clears it.
// (R08) Fetch and clear happen in one edge, so a coincident event stays in the new count.
// (R09) The host should prefer fetch and zero, since events between query and zero are lost.
// (R10) The count lives in volatile state and is zero after power-up reset.
// (R11) A soft restart command or a line break leaves the count untouched.
// (R12) Switch contact inputs are debounced so that bounce adds no counts.
// (R13) The input is synchronised and each qualified pulse counts on its rising edge only.
module pulse_event_accumulator
    import pulse_event_accumulator_pkg::*;
#(
    parameter int debounce_cycles = `PEA_DEBOUNCE_CYCLES,
    parameter int rate_gate_cycles = `PEA_RATE_GATE_CYCLES
) (
    // clock and power-up reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // pulse input and filter choice
    input wire logic pulse_input_zero,
    input wire logic switch_filter_on,
    // serial link status
    input wire logic line_break,
    // host command
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    // answer
    output logic rsp_valid,
    output logic [2:0] rsp_code,
    output rsp_status_type rsp_status,
    output tally_type rsp_data,
    // status
    output logic tally_saturated,
    output logic rate_ready,
    output logic input_level
);

    // ****************************************************************
    // input conditioning
    // ****************************************************************

    pulse_condition_if cond_link ();

    pulse_input_conditioner #(
        .debounce_cycles(debounce_cycles)
    ) u_conditioner (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .raw_input(pulse_input_zero), // [R04]
        .switch_filter_on(switch_filter_on),
        .cond(cond_link.producer)
    );

    // ****************************************************************
    // command decode
    // ****************************************************************

    logic is_rate;
    logic is_query;
    logic is_zero;
    logic is_fetch;
    logic is_restart;
    logic is_known;
    logic measure_restart;

    // one-hot strobes for the command taken on this edge
    always_comb begin
        is_rate = 1'b0;
        is_query = 1'b0;
        is_zero = 1'b0;
        is_fetch = 1'b0;
        is_restart = 1'b0;
        is_known = 1'b0;
        if (cmd_valid) begin
            unique case (cmd_code)
                3'(rate_sample_cmd): begin
                    is_rate = 1'b1;
                    is_known = 1'b1;
                end
                3'(tally_query_cmd): begin
                    is_query = 1'b1;
                    is_known = 1'b1;
                end
                3'(zero_tally_cmd): begin
                    is_zero = 1'b1;
                    is_known = 1'b1;
                end
                3'(fetch_and_zero_cmd): begin
                    is_fetch = 1'b1;
                    is_known = 1'b1;
                end
                3'(host_soft_restart_cmd): begin
                    is_restart = 1'b1;
                    is_known = 1'b1;
                end
                default: begin
                    is_known = 1'b0; // codes 5..7 are illegal
                end
            endcase
        end
    end

    // restart and break only touch the rate meter, never the tally
    assign measure_restart = is_restart || line_break; // [R11]

    // ****************************************************************
    // event tally
    // ****************************************************************

    tally_type tally;
    logic tally_at_max;

    assign tally_at_max = (tally == `PEA_TALLY_MAX);

    // clear and read share one edge; an event on that edge lands in the fresh count
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            tally <= `PEA_TALLY_RESET; // [R10]
        end else if (is_zero || is_fetch) begin
            tally <= cond_link.count_edge ? 24'h000001 : `PEA_TALLY_RESET; // [R06] [R08]
        end else if (cond_link.count_edge && !tally_at_max) begin
            tally <= tally + 24'h000001; // [R01] [R05] [R13]
        end
    end

    assign tally_saturated = tally_at_max; // [R05]

    // ****************************************************************
    // rate meter
    // ****************************************************************

    logic [31:0] gate_count;
    tally_type gate_edges;
    tally_type rate_value;
    logic gate_end;
    logic edges_at_max;

    assign gate_end = (gate_count >= 32'(rate_gate_cycles - 1));
    assign edges_at_max = (gate_edges == `PEA_TALLY_MAX);

    // gate timer restarts with the measurement; the tally is left alone
    always_ff @(posedge sys_clk) begin
        if (!reset_n || measure_restart) begin
            gate_count <= 32'h00000000;
        end else if (gate_end) begin
            gate_count <= 32'h00000000;
        end else begin
            gate_count <= gate_count + 32'h00000001;
        end
    end

    // edges within the gate, saturating so a runaway input cannot wrap
    always_ff @(posedge sys_clk) begin
        if (!reset_n || measure_restart) begin
            gate_edges <= `PEA_RATE_RESET;
        end else if (gate_end) begin
            gate_edges <= `PEA_RATE_RESET;
        end else if (cond_link.rate_edge && !edges_at_max) begin
            gate_edges <= gate_edges + 24'h000001; // [R01]
        end
    end

    // latched rate: edges per gate, including an edge on the closing cycle
    always_ff @(posedge sys_clk) begin
        if (!reset_n || measure_restart) begin
            rate_value <= `PEA_RATE_RESET;
        end else if (gate_end) begin
            rate_value <= (cond_link.rate_edge && !edges_at_max) ?
                          gate_edges + 24'h000001 : gate_edges; // [R02]
        end
    end

    // ready only after a whole gate, so a restart never reports a partial count
    always_ff @(posedge sys_clk) begin
        if (!reset_n || measure_restart) begin
            rate_ready <= 1'b0;
        end else if (gate_end) begin
            rate_ready <= 1'b1; // [R02]
        end
    end

    // ****************************************************************
    // answers
    // ****************************************************************

    tally_type next_data;
    rsp_status_type next_status;

    // value that answers the command taken on this edge
    always_comb begin
        next_data = 24'h000000;
        next_status = rsp_ok;
        if (!is_known) begin
            next_status = rsp_bad_command;
        end else if (is_rate) begin
            next_data = rate_value; // [R02]
            next_status = rate_ready ? rsp_ok : rsp_rate_not_ready;
        end else if (is_query || is_fetch) begin
            next_data = tally; // [R03] [R07]
        end
    end

    // one-cycle answer strobe, set on the same edge that takes the command
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= cmd_valid;
        end
    end

    // echoed code holds until the next answer, so the host can match late reads
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rsp_code <= 3'h0;
        end else if (cmd_valid) begin
            rsp_code <= cmd_code;
        end
    end

    // status tells the host whether the payload means anything
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rsp_status <= rsp_ok;
        end else if (cmd_valid) begin
            rsp_status <= next_status;
        end
    end

    // data is the value as it stood before the taking edge
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rsp_data <= 24'h000000;
        end else if (cmd_valid) begin
            rsp_data <= next_data; // [R03] [R07]
        end
    end

    assign input_level = cond_link.input_level;

endmodule // pulse_event_accumulator

// ===== verif/pulse_event_accumulator_monitor.sv
// port checker for the pulse event accumulator
`timescale 1ns/100ps
`include "pulse_event_accumulator_regs.svh"
module pulse_event_accumulator_monitor
    import pulse_event_accumulator_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // inputs
    input wire logic pulse_input_zero,
    input wire logic switch_filter_on,
    input wire logic line_break,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    // outputs
    input wire logic rsp_valid,
    input wire logic [2:0] rsp_code,
    input wire rsp_status_type rsp_status,
    input wire tally_type rsp_data,
    input wire logic tally_saturated,
    input wire logic rate_ready,
    input wire logic input_level
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // ****
    // command steps
    // ****
    sequence s_query;
        cmd_valid && cmd_code == 3'h1;
    endsequence
    // fetch with no count edge landing on the same clock
    sequence s_fetch_quiet;
        cmd_valid && cmd_code == 3'h3 && !switch_filter_on && !$rose(input_level);
    endsequence
    sequence s_fetch_hit;
        cmd_valid && cmd_code == 3'h3 && !switch_filter_on && $rose(input_level);
    endsequence
    // idle cycle with no count edge between fetch and query
    sequence s_gap;
        !cmd_valid && !switch_filter_on && !$rose(input_level);
    endsequence

    property p_answer;
        cmd_valid |=> rsp_valid && rsp_code == $past(cmd_code);
    endproperty
    a_answer: assert property (p_answer) else $error("answer missing");
    property p_not_ready;
        cmd_valid && cmd_code == 3'h0 && !rate_ready |=> rsp_status == rsp_rate_not_ready;
    endproperty
    a_not_ready: assert property (p_not_ready) else $error("early rate");
    property p_zero;
        cmd_valid && cmd_code == 3'h2 |=> rsp_data == 24'h000000 && rsp_status == rsp_ok;
    endproperty
    a_zero: assert property (p_zero) else $error("zero answer");
    property p_fetch_quiet;
        s_fetch_quiet ##1 s_gap ##1 s_query |=> rsp_data == 24'h000000;
    endproperty
    a_fetch_quiet: assert property (p_fetch_quiet) else $error("not cleared");
    property p_fetch_hit;
        s_fetch_hit ##1 s_gap ##1 s_query |=> rsp_data == 24'h000001;
    endproperty
    a_fetch_hit: assert property (p_fetch_hit) else $error("event lost");
    property p_sync;
        $past(reset_n, 2) && $past(reset_n) |-> input_level == $past(pulse_input_zero, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("sync delay");
    property p_sat_hold;
        tally_saturated && !(cmd_valid && cmd_code inside {3'h2, 3'h3}) |=> tally_saturated;
    endproperty
    a_sat_hold: assert property (p_sat_hold) else $error("left max");
    property p_sat_query;
        tally_saturated ##0 s_query |=> rsp_data == `PEA_TALLY_MAX;
    endproperty
    a_sat_query: assert property (p_sat_query) else $error("max value");
    property p_reset;
        $rose(reset_n) |-> !rsp_valid && rsp_data == 24'h000000 && !tally_saturated;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state");
endmodule // pulse_event_accumulator_monitor

bind pulse_event_accumulator pulse_event_accumulator_monitor i_monitor (
    .sys_clk(sys_clk), .reset_n(reset_n), .pulse_input_zero(pulse_input_zero),
    .switch_filter_on(switch_filter_on), .line_break(line_break), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .rsp_valid(rsp_valid), .rsp_code(rsp_code), .rsp_status(rsp_status),
    .rsp_data(rsp_data), .tally_saturated(tally_saturated), .rate_ready(rate_ready),
    .input_level(input_level)
);

// ===== verif/host_cmd_model.sv
// host side of the command port
`timescale 1ns/100ps
module host_cmd_model (
    // clock
    input wire logic sys_clk,
    // bench request
    input wire logic send_req,
    input wire logic [2:0] send_code,
    // command port
    output logic cmd_valid,
    output logic [2:0] cmd_code
);
    logic [2:0] idle_code = 3'h0;

    // code wanders off-strobe so a design that ignores cmd_valid shows it
    always @(posedge sys_clk) begin
        idle_code <= idle_code + 3'h5;
    end

    // one strobe per command; read and clear is asked as one fetch
    always_comb begin
        cmd_valid = send_req;
        cmd_code = send_req ? send_code : idle_code;
    end
endmodule // host_cmd_model

// ===== verif/tb_pulse_event_accumulator.sv
// self-checking bench for the pulse event accumulator
`timescale 1ns/100ps
module tb_pulse_event_accumulator
    import pulse_event_accumulator_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic raw = 1'b0;
    logic filt = 1'b0;
    logic brk = 1'b0;
    logic send_req = 1'b0;
    logic [2:0] send_code = 3'h0;
    logic cmd_valid;
    logic [2:0] cmd_code;
    logic rsp_valid;
    logic [2:0] rsp_code;
    rsp_status_type rsp_status;
    tally_type rsp_data;
    logic sat;
    logic rdy;
    logic lvl;
    int failures = 0;
    int n_compared = 0;
    int seed = 32'he0d97acf;
    int n;
    tally_type total;
    tally_type got;

    always #2 sys_clk = ~sys_clk;

    host_cmd_model i_host (.sys_clk(sys_clk), .send_req(send_req), .send_code(send_code),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code));
    // short debounce and gate keep the run brief
    pulse_event_accumulator #(.debounce_cycles(4), .rate_gate_cycles(50)) i_dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .pulse_input_zero(raw),
        .switch_filter_on(filt), .line_break(brk), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .rsp_valid(rsp_valid), .rsp_code(rsp_code),
        .rsp_status(rsp_status), .rsp_data(rsp_data), .tally_saturated(sat),
        .rate_ready(rdy), .input_level(lvl));

    // expected tally, stopping at the top value
    function automatic tally_type sat_add(tally_type a, int k);
        return (int'(a) + k > 9999999) ? 24'h98967f : tally_type'(int'(a) + k);
    endfunction

    task automatic check_data(tally_type g, tally_type e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t data %h want %h", $time, g, e);
        end
    endtask

    task automatic check_bit(logic g, logic e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t flag %b want %b", $time, g, e);
        end
    endtask

    task automatic check_rsp(logic [2:0] c, rsp_status_type s);
        n_compared++;
        if (rsp_valid !== 1'b1 || rsp_code !== c || rsp_status !== s) begin
            failures++;
            $display("BAD %0t answer %b %h %0d", $time, rsp_valid, rsp_code, rsp_status);
        end
    endtask

    // answer is looked at mid-cycle after the taking edge
    task automatic send(logic [2:0] c, rsp_status_type s, output tally_type d);
        @(posedge sys_clk) send_req <= 1'b1;
        send_code <= c;
        @(posedge sys_clk) send_req <= 1'b0;
        @(negedge sys_clk);
        check_rsp(c, s);
        d = rsp_data;
    endtask

    task automatic pulse(int h, int l);
        repeat (h) @(posedge sys_clk) raw <= 1'b1;
        repeat (l) @(posedge sys_clk) raw <= 1'b0;
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // watchdog well past the expected several hundred cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        $display("BAD %0t watchdog", $time);
        tally_and_finish;
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        send(3'h1, rsp_ok, got);
        check_data(got, 24'h000000);
        send(3'h0, rsp_rate_not_ready, got);
        for (int c = 5; c < 8; c++) begin
            send(3'(c), rsp_bad_command, got);
            check_data(got, 24'h000000);
        end
        // random trains, alternating raw and debounced counting
        total = 24'h000000;
        for (int r = 0; r < 6; r++) begin
            @(posedge sys_clk) filt <= r[0];
            n = 1 + ($unsigned($random(seed)) % 8);
            for (int p = 0; p < n; p++)
                pulse((r[0] ? 7 : 1) + $unsigned($random(seed)) % 3, r[0] ? 8 : 2);
            repeat (12) @(posedge sys_clk);
            total = sat_add(total, n);
            send(3'h1, rsp_ok, got);
            check_data(got, total);
            check_bit(sat, total == 24'h98967f);
        end
        // bounce shorter than the filter window adds nothing
        for (int b = 0; b < 4; b++)
            pulse(2, 2);
        pulse(12, 12);
        send(3'h3, rsp_ok, got);
        check_data(got, sat_add(total, 1));
        send(3'h1, rsp_ok, got);
        check_data(got, 24'h000000);
        @(posedge sys_clk) filt <= 1'b0;
        pulse(1, 1);
        // let the count land before the clear, so the clear has something to remove
        repeat (4) @(posedge sys_clk);
        send(3'h1, rsp_ok, got);
        check_data(got, 24'h000001);
        send(3'h2, rsp_ok, got);
        check_data(got, 24'h000000);
        send(3'h1, rsp_ok, got);
        check_data(got, 24'h000000);
        // slide one edge across a fetch: it lands on one side only
        for (int k = 0; k < 5; k++) begin
            @(posedge sys_clk) raw <= 1'b1;
            repeat (k) @(posedge sys_clk);
            send(3'h3, rsp_ok, total);
            send(3'h1, rsp_ok, got);
            check_data(total + got, 24'h000001);
            check_bit(lvl, 1'b1);
            @(posedge sys_clk) raw <= 1'b0;
            repeat (6) @(posedge sys_clk);
            send(3'h3, rsp_ok, total);
            check_data(total, got);
        end
        // same edges reach the rate meter and the tally
        fork
            repeat (40) pulse(2, 3);
            begin
                repeat (130) @(posedge sys_clk);
                send(3'h0, rsp_ok, got);
                check_data(got, 24'h00000a);
            end
        join
        send(3'h1, rsp_ok, got);
        check_data(got, 24'h000028);
        check_bit(rdy, 1'b1);
        send(3'h4, rsp_ok, got);
        @(posedge sys_clk) brk <= 1'b1;
        repeat (3) @(posedge sys_clk) brk <= 1'b0;
        send(3'h0, rsp_rate_not_ready, got);
        check_bit(rdy, 1'b0);
        send(3'h1, rsp_ok, got);
        check_data(got, 24'h000028);
        tally_and_finish;
    end
endmodule // tb_pulse_event_accumulator
